//--- verilog/pmcb_pkg.sv
/*
 * Shared constants and types for the pad mode configuration bank: register
 * index and byte addresses, field positions, reset values, pull/direction
 * codes and the carrier structs.
 * Assumes a single pclk domain and an APB slave with a 12-bit local address.
 */
`default_nettype none

package pmcb_pkg;

  // ****************************************************************
  // Bank geometry
  // ****************************************************************
  localparam int PMCB_NPIN   = 5;         // Pins 3.6, 3.7, 4.0, 4.1, 4.2
  localparam int PMCB_AW     = 12;        // Local APB address width
  localparam int PMCB_DW     = 32;        // APB data width
  localparam int PMCB_CFG_W  = 16;        // Width of one config register

  // ****************************************************************
  // Register indices and byte addresses (byte address = 4 x index)
  // ****************************************************************
  localparam logic [31:0] PMCB_IDX_P3_6 = 32'h5000_305A;  // port3_pin6_config
  localparam logic [31:0] PMCB_IDX_P3_7 = 32'h5000_305C;  // port3_pin7_config
  localparam logic [31:0] PMCB_IDX_P4_0 = 32'h5000_305E;  // port4_pin0_config
  localparam logic [31:0] PMCB_IDX_P4_1 = 32'h5000_3060;  // port4_pin1_config
  localparam logic [31:0] PMCB_IDX_P4_2 = 32'h5000_3062;  // port4_pin2_config
  // Low address bits of four times each index, as the slave decodes them
  localparam logic [PMCB_AW-1:0] PMCB_ADDR [PMCB_NPIN] = '{
    {PMCB_IDX_P3_6[9:0], 2'h0},
    {PMCB_IDX_P3_7[9:0], 2'h0},
    {PMCB_IDX_P4_0[9:0], 2'h0},
    {PMCB_IDX_P4_1[9:0], 2'h0},
    {PMCB_IDX_P4_2[9:0], 2'h0}
  };
  localparam logic [PMCB_AW-1:0] PMCB_ADDR_LEVEL = 12'h190;  // Pad level status

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int PMCB_OD_BIT = 10;        // open_drain_select
  localparam int PMCB_PD_HI  = 9;         // pull_direction_select
  localparam int PMCB_PD_LO  = 8;
  localparam int PMCB_FS_HI  = 5;         // function_select
  localparam int PMCB_FS_LO  = 0;
  localparam logic [PMCB_CFG_W-1:0] PMCB_CFG_WMASK = 16'h073F;  // Writable bits
  localparam logic [PMCB_CFG_W-1:0] PMCB_CFG_RST   = 16'h0200;  // Pull-down input

  // Pull/direction codes
  typedef enum logic [1:0] {
    PMCB_IN_NOPULL   = 2'b00,
    PMCB_IN_PULLUP   = 2'b01,
    PMCB_IN_PULLDOWN = 2'b10,
    PMCB_OUT_NOPULL  = 2'b11
  } pmcb_pd_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  // Decoded pad controls towards the pad ring
  typedef struct packed {
    logic       out_en;       // Output driver enabled
    logic       pull_up;      // Pull-up resistor connected
    logic       pull_dn;      // Pull-down resistor connected
    logic       open_drain;   // Driver is open drain
    logic [5:0] func_sel;     // Function-select code
  } pmcb_pad_ctl_t;

  // Write request for one config register
  typedef struct packed {
    logic                  en;    // Write takes effect this edge
    logic [1:0]            strb;  // Byte lanes
    logic [PMCB_CFG_W-1:0] data;  // Write data
  } pmcb_wr_t;

  localparam pmcb_pad_ctl_t PMCB_CTL_RST = '{out_en: 1'h0, pull_up: 1'h0,
                                             pull_dn: 1'h1, open_drain: 1'h0,
                                             func_sel: 6'h00};

endpackage

`default_nettype wire

//--- verilog/pmcb_pad_cfg.sv
/*
 * One pad of the bank: its config register, the decode into pad controls,
 * the pad driver and the input synchroniser.
 * Assumes writes come from the APB slave in the same pclk domain and that
 * adc_mode and pad_dout come from logic on pclk.
 */
`timescale 1ns/100ps
`default_nettype none

module pmcb_pad_cfg (
  // Clock and reset
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  // Register access
  input  wire pmcb_pkg::pmcb_wr_t                wr,
  output logic [pmcb_pkg::PMCB_CFG_W-1:0]        cfg_q,
  // Pad mode and core data
  input  wire logic                              adc_mode,
  input  wire logic                              pad_dout,
  // Pad pins
  input  wire logic                              pad_i,
  output logic                                   pad_o,
  output logic                                   pad_oe,
  output logic                                   pad_din,
  // Decoded controls
  output pmcb_pkg::pmcb_pad_ctl_t                ctl
);
  import pmcb_pkg::*;

  // ****************************************************************
  // Config register
  // ****************************************************************
  logic [PMCB_CFG_W-1:0] cfg_ff;        // Stored config
  logic [PMCB_CFG_W-1:0] nxt_cfg;       // Next config
  logic [PMCB_CFG_W-1:0] wr_bits;       // Bits this write may touch

  // Reserved bits never take a write, so they always read zero
  assign wr_bits = {{8{wr.strb[1]}}, {8{wr.strb[0]}}} & PMCB_CFG_WMASK;
  assign nxt_cfg = wr.en ? ((cfg_ff & ~wr_bits) | (wr.data & wr_bits)) : cfg_ff;

  // Register update; reset gives a pull-down input, push-pull
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= PMCB_CFG_RST;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end
  assign cfg_q = cfg_ff;

  // ****************************************************************
  // Decode
  // ****************************************************************
  pmcb_pd_t      pd_sel;                // Pull/direction code
  logic          drive_out;             // Pad is an output
  pmcb_pad_ctl_t nxt_ctl;               // Next decoded controls
  logic          nxt_pad_o;             // Next pad output level
  logic          nxt_pad_oe;            // Next pad output enable

  assign pd_sel    = pmcb_pd_t'(cfg_ff[PMCB_PD_HI:PMCB_PD_LO]);
  // ADC mode overrides the field: no driver, no pulls
  assign drive_out = !adc_mode && (pd_sel == PMCB_OUT_NOPULL);
  assign nxt_ctl.out_en     = drive_out;
  assign nxt_ctl.pull_up    = !adc_mode && (pd_sel == PMCB_IN_PULLUP);
  assign nxt_ctl.pull_dn    = !adc_mode && (pd_sel == PMCB_IN_PULLDOWN);
  assign nxt_ctl.open_drain = cfg_ff[PMCB_OD_BIT];
  assign nxt_ctl.func_sel   = cfg_ff[PMCB_FS_HI:PMCB_FS_LO];

  // Open drain only ever pulls low; a high is left to the external pull
  assign nxt_pad_oe = drive_out && (!cfg_ff[PMCB_OD_BIT] || !pad_dout);
  assign nxt_pad_o  = pad_dout && !cfg_ff[PMCB_OD_BIT];

  // ****************************************************************
  // Output and synchroniser flops
  // ****************************************************************
  pmcb_pad_ctl_t ctl_ff;                // Registered controls
  logic          pad_o_ff;              // Registered pad level
  logic          pad_oe_ff;             // Registered pad enable
  logic          meta_ff;               // First sync stage, read by din_ff only
  logic          din_ff;                // Second sync stage

  // Controls follow the register one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff    <= PMCB_CTL_RST;
      pad_o_ff  <= 1'h0;
      pad_oe_ff <= 1'h0;
    end else begin
      ctl_ff    <= nxt_ctl;
      pad_o_ff  <= nxt_pad_o;
      pad_oe_ff <= nxt_pad_oe;
    end
  end

  // Pad level is asynchronous to pclk, so two flops before any use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= 1'h0;
      din_ff  <= 1'h0;
    end else begin
      meta_ff <= pad_i;
      din_ff  <= meta_ff;
    end
  end

  assign ctl     = ctl_ff;
  assign pad_o   = pad_o_ff;
  assign pad_oe  = pad_oe_ff;
  assign pad_din = din_ff;

endmodule

`default_nettype wire

//--- verilog/pmcb_top.sv
/*
 * Pad mode configuration bank: APB slave holding five pad config
 * registers and a read-only pad level word, plus the pad drivers.
 * Assumes an APB master on pclk with a block-local 12-bit byte address,
 * and adc_mode and pad_dout driven by logic on pclk.
 */
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module pmcb_top (
  // Clock and reset
  input  wire logic                                          pclk,
  input  wire logic                                          presetn,
  // APB slave
  input  wire logic                                          psel,
  input  wire logic                                          penable,
  input  wire logic                                          pwrite,
  input  wire logic [pmcb_pkg::PMCB_AW-1:0]                  paddr,
  input  wire logic [pmcb_pkg::PMCB_DW-1:0]                  pwdata,
  input  wire logic [3:0]                                    pstrb,
  output logic [pmcb_pkg::PMCB_DW-1:0]                       prdata,
  output logic                                               pready,
  output logic                                               pslverr,
  // Per-pad mode and core data
  input  wire logic [pmcb_pkg::PMCB_NPIN-1:0]                adc_mode,
  input  wire logic [pmcb_pkg::PMCB_NPIN-1:0]                pad_dout,
  // Pad pins
  input  wire logic [pmcb_pkg::PMCB_NPIN-1:0]                pad_i,
  output logic [pmcb_pkg::PMCB_NPIN-1:0]                     pad_o,
  output logic [pmcb_pkg::PMCB_NPIN-1:0]                     pad_oe,
  output logic [pmcb_pkg::PMCB_NPIN-1:0]                     pad_din,
  // Decoded pad controls
  output pmcb_pkg::pmcb_pad_ctl_t [pmcb_pkg::PMCB_NPIN-1:0]  pad_ctl
);
  import pmcb_pkg::*;

  // ****************************************************************
  // APB phase and address decode
  // ****************************************************************
  wire                  apb_setup;              // Setup phase
  wire                  apb_access;             // Access phase
  wire [PMCB_NPIN-1:0]  hit_cfg;                // Config register selected
  wire                  hit_level;              // Level word selected
  wire                  mapped;                 // Any register selected

  assign apb_setup  = psel && !penable;
  assign apb_access = psel && penable;
  assign hit_level  = (paddr == PMCB_ADDR_LEVEL);
  assign mapped     = (|hit_cfg) || hit_level;

  // Zero wait states: every access completes in its first access cycle
  // Trade-off: no wait states keep the master simple, but decode and
  // the read mux must settle within one pclk period
  assign pready  = apb_access;
  // Unmapped addresses answer with an error and change nothing
  assign pslverr = apb_access && !mapped;

  // ****************************************************************
  // Pad instances and read data chain
  // ****************************************************************
  logic [PMCB_CFG_W-1:0] cfg_q   [PMCB_NPIN];   // Register contents
  pmcb_wr_t              wr_req  [PMCB_NPIN];   // Per-pad write request
  logic [PMCB_DW-1:0]    rd_chain[PMCB_NPIN+1]; // OR chain of read terms

  // At most one term of the OR chain is non-zero, as the addresses are
  // distinct; an unmapped address therefore reads zero
  assign rd_chain[0] = hit_level ? {{(PMCB_DW-PMCB_NPIN){1'h0}}, pad_din}
                                 : {PMCB_DW{1'h0}};

  genvar gi;
  generate
    for (gi = 0; gi < PMCB_NPIN; gi++) begin : g_pad
      // Address match for this pad
      assign hit_cfg[gi] = (paddr == PMCB_ADDR[gi]);

      // Write lands at the access edge only; upper byte lanes unused
      assign wr_req[gi].en   = apb_access && pwrite && hit_cfg[gi];
      assign wr_req[gi].strb = pstrb[1:0];
      assign wr_req[gi].data = pwdata[PMCB_CFG_W-1:0];

      // Narrow register sits in the low half-word, upper bits read zero
      assign rd_chain[gi+1] = rd_chain[gi] |
                              (hit_cfg[gi] ? {{(PMCB_DW-PMCB_CFG_W){1'h0}}, cfg_q[gi]}
                                           : {PMCB_DW{1'h0}});

      pmcb_pad_cfg u_pad (
        .pclk     (pclk),
        .presetn  (presetn),
        .wr       (wr_req[gi]),
        .cfg_q    (cfg_q[gi]),
        .adc_mode (adc_mode[gi]),
        .pad_dout (pad_dout[gi]),
        .pad_i    (pad_i[gi]),
        .pad_o    (pad_o[gi]),
        .pad_oe   (pad_oe[gi]),
        .pad_din  (pad_din[gi]),
        .ctl      (pad_ctl[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Read data register
  // ****************************************************************
  logic [PMCB_DW-1:0] prdata_ff;              // Read word held for access

  // Sampled in setup; nothing else can change a register before access
  // Limitation: a level read shows pad_din as it stood in setup, one
  // cycle older than the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= {PMCB_DW{1'h0}};
    end else if (apb_setup && !pwrite) begin
      prdata_ff <= rd_chain[PMCB_NPIN];
    end
  end
  assign prdata = prdata_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Bus answer in the first access cycle, error only when unmapped
  a_apb_answer: assert property (apb_setup ##1 apb_access |-> pready &&
                                 (pslverr == !$past(mapped)))
    else $error("APB access not answered as expected");

  // Answer lines are combinational, so check they stay low when idle
  // and in setup; a stray answer would end a transfer early
  a_apb_idle: assert property (!apb_access |-> !pready && !pslverr)
    else $error("APB answer outside access phase");

  // Level word reads the synchronised levels taken in setup
  a_level_read: assert property (apb_access && !pwrite && hit_level |->
                                 prdata == {{(PMCB_DW-PMCB_NPIN){1'h0}}, $past(pad_din)})
    else $error("Pad level word read wrong");

  // The level word is mapped, so any access to it is answered cleanly
  a_level_no_err: assert property (apb_access && hit_level |-> !pslverr)
    else $error("Level word access flagged as error");

  generate
    for (gi = 0; gi < PMCB_NPIN; gi++) begin : g_chk
      // Open drain never drives the pad high
      a_od_no_high: assert property (pad_ctl[gi].open_drain && pad_oe[gi] |-> !pad_o[gi])
        else $error("Open-drain pad driven high");

      // Push-pull output drives the core level one cycle later
      a_pp_drive: assert property (!cfg_q[gi][PMCB_OD_BIT] && !adc_mode[gi] &&
                                   cfg_q[gi][PMCB_PD_HI:PMCB_PD_LO] == PMCB_OUT_NOPULL
                                   |=> pad_oe[gi] && (pad_o[gi] == $past(pad_dout[gi])))
        else $error("Push-pull output not driven");

      // Open drain drives only a low and releases the pad for a high
      a_od_drive: assert property (cfg_q[gi][PMCB_OD_BIT] && !adc_mode[gi] &&
                                   cfg_q[gi][PMCB_PD_HI:PMCB_PD_LO] == PMCB_OUT_NOPULL
                                   |=> (pad_oe[gi] == !$past(pad_dout[gi])) && !pad_o[gi])
        else $error("Open-drain output wrong");

      // Input codes select the matching resistor and no driver
      a_in_pull_sel: assert property (!adc_mode[gi] && !cfg_q[gi][PMCB_PD_HI]
                                      |=> !pad_ctl[gi].out_en && !pad_oe[gi] &&
                                      !pad_ctl[gi].pull_dn &&
                                      (pad_ctl[gi].pull_up == $past(cfg_q[gi][PMCB_PD_LO])))
        else $error("Input pull selection wrong");

      a_in_pull_down: assert property (!adc_mode[gi] &&
                                       cfg_q[gi][PMCB_PD_HI:PMCB_PD_LO] == PMCB_IN_PULLDOWN
                                       |=> pad_ctl[gi].pull_dn && !pad_ctl[gi].pull_up &&
                                       !pad_oe[gi])
        else $error("Pull-down input wrong");

      // Output code: driver on, both resistors off
      a_out_no_pull: assert property (!adc_mode[gi] &&
                                      cfg_q[gi][PMCB_PD_HI:PMCB_PD_LO] == PMCB_OUT_NOPULL
                                      |=> pad_ctl[gi].out_en && !pad_ctl[gi].pull_up &&
                                      !pad_ctl[gi].pull_dn)
        else $error("Output pad has pull or no driver");

      // First edge after reset release sees the reset config
      a_reset_cfg: assert property ($past(!presetn) |-> cfg_q[gi] == PMCB_CFG_RST &&
                                    pad_ctl[gi] == PMCB_CTL_RST)
        else $error("Config not at reset value");

      // ADC mode: field ignored, pad neither pulled nor driven
      a_adc_ignore: assert property (adc_mode[gi] |=> !pad_ctl[gi].out_en &&
                                     !pad_ctl[gi].pull_up && !pad_ctl[gi].pull_dn &&
                                     !pad_oe[gi])
        else $error("ADC pad still pulled or driven");

      // Reserved bits always zero, writable bits take a full write
      a_rsvd_zero: assert property ((cfg_q[gi] & ~PMCB_CFG_WMASK) == 16'h0000)
        else $error("Reserved config bits set");

      a_write_lands: assert property (wr_req[gi].en && wr_req[gi].strb == 2'h3
                                      |=> cfg_q[gi] == ($past(wr_req[gi].data) &
                                      PMCB_CFG_WMASK))
        else $error("Config write not stored");

      // Without a write the register keeps its value
      a_cfg_hold: assert property (!wr_req[gi].en |=> $stable(cfg_q[gi]))
        else $error("Config changed without a write");

      // Config read returns the register as it stood in setup
      a_cfg_read: assert property (apb_access && !pwrite && hit_cfg[gi] |->
                                   prdata == {{(PMCB_DW-PMCB_CFG_W){1'h0}}, $past(cfg_q[gi])})
        else $error("Config read data wrong");

      // A refused access never touches a config register
      a_no_stray_wr: assert property (pslverr |-> !wr_req[gi].en)
        else $error("Refused access wrote a register");

      // Pad level reaches the core two edges after the pin
      a_din_sync: assert property ($past(presetn) && $past(presetn, 2) |->
                                   pad_din[gi] == $past(pad_i[gi], 2))
        else $error("Pad level not synchronised");

      // Function code reaches the pad controls one cycle later
      a_func_follow: assert property (1'h1 |=> pad_ctl[gi].func_sel ==
                                      $past(cfg_q[gi][PMCB_FS_HI:PMCB_FS_LO]))
        else $error("Function code not forwarded");
    end
  endgenerate

endmodule

`default_nettype wire

//--- tb/pmcb_pad_env.sv
/*
 * Model of the circuitry outside the five pads: bench-commanded drivers,
 * the pull resistors and a floating wire.
 * Assumes pad controls and drivers come from the bank on pclk.
 */
`timescale 1ns/100ps
`default_nettype none

module pmcb_pad_env (
  // Clock
  input  wire logic                                     pclk,
  // Pad side of the bank
  input  wire logic [pmcb_pkg::PMCB_NPIN-1:0]           pad_o,
  input  wire logic [pmcb_pkg::PMCB_NPIN-1:0]           pad_oe,
  input  wire pmcb_pkg::pmcb_pad_ctl_t [pmcb_pkg::PMCB_NPIN-1:0] pad_ctl,
  // External drivers commanded by the bench
  input  wire logic [pmcb_pkg::PMCB_NPIN-1:0]           ext_en,
  input  wire logic [pmcb_pkg::PMCB_NPIN-1:0]           ext_val,
  // Resolved pad levels
  output logic [pmcb_pkg::PMCB_NPIN-1:0]                pad_i
);
  import pmcb_pkg::*;

  // ****************************************************************
  // Wire resolution
  // ****************************************************************
  // An undriven, unpulled wire changes every cycle, so a stale level
  // can never pass for a real one
  logic [PMCB_NPIN-1:0] float_ff = 5'h00;

  always @(posedge pclk) begin
    float_ff <= ~float_ff;
  end

  // Bank driver wins, then external driver, then resistors
  always_comb begin
    for (int i = 0; i < PMCB_NPIN; i++) begin
      if (pad_oe[i]) pad_i[i] = pad_o[i];
      else if (ext_en[i]) pad_i[i] = ext_val[i];
      else if (pad_ctl[i].pull_up) pad_i[i] = 1'b1;
      else if (pad_ctl[i].pull_dn) pad_i[i] = 1'b0;
      else pad_i[i] = float_ff[i];
    end
  end
endmodule

`default_nettype wire

//--- tb/pmcb_top_tb.sv
/*
 * Self-checking bench for the pad mode bank: APB accesses, pad decode,
 * ADC override, pad level capture and refusals.
 * Assumes the pad model in pmcb_pad_env and a 100 MHz pclk.
 */
`timescale 1ns/100ps
`default_nettype none

module pmcb_top_tb;
  import pmcb_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic                          pclk = 1'b0;
  logic                          presetn = 1'b0;
  logic                          psel, penable, pwrite, pslverr, pready;
  logic [PMCB_AW-1:0]            paddr;
  logic [PMCB_DW-1:0]            pwdata, prdata, rd;
  logic [3:0]                    pstrb;
  logic [PMCB_NPIN-1:0]          adc_mode, pad_dout, pad_i, pad_o, pad_oe, pad_din;
  logic [PMCB_NPIN-1:0]          ext_en, ext_val;
  pmcb_pad_ctl_t [PMCB_NPIN-1:0] pad_ctl;
  logic                          err;
  int                            n_errors = 0;
  int                            n_tests = 0;
  int                            cyc = 0;

  always #5 pclk = ~pclk;

  pmcb_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .adc_mode(adc_mode), .pad_dout(pad_dout),
    .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe), .pad_din(pad_din), .pad_ctl(pad_ctl));

  pmcb_pad_env u_env (.pclk(pclk), .pad_o(pad_o), .pad_oe(pad_oe), .pad_ctl(pad_ctl),
    .ext_en(ext_en), .ext_val(ext_val), .pad_i(pad_i));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Verdict and end of run, from the main sequence or the timeout
  task automatic close_out();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Compare a seen value with an expected one
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; an idle edge first keeps psel from being set twice
  // Waits for pready with no limit of its own: the bench timeout ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Expected pad controls from a config word and the ADC flag
  function automatic pmcb_pad_ctl_t ectl(input logic [15:0] c, input logic a);
    return '{out_en: !a && c[9:8] == 2'b11, pull_up: !a && c[9:8] == 2'b01,
             pull_dn: !a && c[9:8] == 2'b10, open_drain: c[10], func_sel: c[5:0]};
  endfunction

  // ****************************************************************
  // Timeout
  // ****************************************************************
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin : main
    logic [15:0]   c;
    logic          adc, od, dv, eoe, lvl;
    logic [PMCB_NPIN-1:0] elv;
    logic [1:0]    pd;
    pmcb_pad_ctl_t ec;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {adc_mode, pad_dout, ext_en, ext_val} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Reset state: pull-down inputs, push-pull, code zero
    for (int i = 0; i < PMCB_NPIN; i++) begin
      chk(32'(pad_ctl[i]), 32'(ectl(16'h0200, 1'b0)), "reset ctl");
      chk(32'(pad_din[i]), 32'h0, "reset level");
      apb(1'b0, PMCB_ADDR[i], 32'h0, 4'h0);
      chk(rd, 32'h0000_0200, "reset value");
    end
    // Every code, driver type, data level and ADC state on all pins
    for (int m = 0; m < 32; m++) begin
      {adc, od, pd, dv} = 5'(m);
      adc_mode <= {PMCB_NPIN{adc}};
      pad_dout <= {PMCB_NPIN{dv}};
      // Resistors are tested with the wire left free
      ext_en   <= {PMCB_NPIN{adc || pd == 2'b00 || pd == 2'b11}};
      ext_val  <= {PMCB_NPIN{~dv}};
      for (int i = 0; i < PMCB_NPIN; i++) begin
        c = {5'h00, od, pd, 2'h0, 6'(i * 11 + m)};
        apb(1'b1, PMCB_ADDR[i], 32'hFFFF_F8C0 | 32'(c), 4'hF);
      end
      repeat (5) @(posedge pclk);
      for (int i = 0; i < PMCB_NPIN; i++) begin
        c   = {5'h00, od, pd, 2'h0, 6'(i * 11 + m)};
        ec  = ectl(c, adc);
        eoe = ec.out_en && (!od || !dv);
        lvl = eoe ? (!od && dv) : (ext_en[i] ? ~dv : ec.pull_up);
        chk(32'(pad_ctl[i]), 32'(ec), "pad ctl");
        chk(32'(pad_oe[i]), 32'(eoe), "pad oe");
        if (eoe) chk(32'(pad_o[i]), 32'(!od && dv), "pad out");
        chk(32'(pad_din[i]), 32'(lvl), "pad level");
        elv[i] = lvl;
        apb(1'b0, PMCB_ADDR[i], 32'h0, 4'h0);
        chk(rd, 32'(c), "readback");
      end
      // The level word shows the same synchronised levels
      apb(1'b0, PMCB_ADDR_LEVEL, 32'h0, 4'h0);
      chk(rd, 32'(elv), "level word");
    end
    // Byte lane 0 only: high byte keeps its value
    apb(1'b1, PMCB_ADDR[0], 32'h0000_0000, 4'h1);
    apb(1'b0, PMCB_ADDR[0], 32'h0, 4'h0);
    chk(rd, 32'h0000_0700, "lane write");
    // Unmapped address refused and harmless
    apb(1'b1, 12'h16C, 32'h0000_0000, 4'hF);
    chk(32'(err), 32'h1, "unmapped write");
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    chk(32'(err), 32'h1, "unmapped read");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b0, PMCB_ADDR[0], 32'h0, 4'h0);
    chk(rd, 32'h0000_0700, "after unmapped");
    // Lane 1 only: low byte keeps its value, reserved bits stay zero
    apb(1'b1, PMCB_ADDR[0], 32'hFFFF_F9FF, 4'h2);
    apb(1'b0, PMCB_ADDR[0], 32'h0, 4'h0);
    chk(rd, 32'h0000_0100, "lane 1 write");
    // The level word takes no write and raises no error
    apb(1'b1, PMCB_ADDR_LEVEL, 32'hFFFF_FFFF, 4'hF);
    chk(32'(err), 32'h0, "level write");
    // Second reset in mid-run restores the pull-down input state
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < PMCB_NPIN; i++) begin
      apb(1'b0, PMCB_ADDR[i], 32'h0, 4'h0);
      chk(rd, 32'h0000_0200, "second reset");
    end
    close_out();
  end
endmodule

`default_nettype wire
